// ---- verilog/spfm_mux.sv ----
// Purpose: Ownership of the six shared port A pins, plus port B.
// Assumes: Pin inputs synchronous to clk_i; one clock, sync reset.
// Notes:   Every pin and function output is registered, one cycle late.
`default_nettype none
// Summary of operation
// R1: After reset all enables clear, so every pin is a plain input.
// R2: Pin 0 order: analog 0, timer channel 0, keypad 0, port.
// R3: Pin 1 order: analog 1, timer channel 1, keypad 1, port.
// R4: Pin 2 order: external interrupt, keypad 2, timer clock, port.
// R5: Pin 3 order: reset input, keypad 3, port.
// R6: Pin 4 order: oscillator output, analog 2, keypad 4, port.
// R7: Pin 5 order: oscillator input, analog 3, keypad 5, port.
// R8: Pin 2 is input only; its driver is never enabled.
// R9: RC or internal clock drives pin 4 only with clock out enabled.
// R10: Crystal mode uses pin 4 as amplifier output regardless of enable.
// R11: Port B lines exist only in the larger package variant.
// R12: Interrupt use of pin 2 adds selectable pullup and Schmitt input.
// R13: Only the highest enabled function drives and receives the pin; the port data read sees the pin on inputs and the data latch on outputs.
module spfm_mux
	import spfm_pkg::*;
#(
	parameter bit HAS_PORT_B = 1'b1
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Register port
	input  wire logic [ADDR_W-1:0] reg_addr_i,
	input  wire logic [DATA_W-1:0] reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	output logic      [DATA_W-1:0] reg_rdata_o,
	// Port A pins
	input  wire logic [NUM_PA-1:0] pa_in_i,
	output logic      [NUM_PA-1:0] pa_out_o,
	output logic      [NUM_PA-1:0] pa_oe_o,
	output logic      [NUM_PA-1:0] pa_pullup_o,
	output logic                   pa_schmitt_o,
	// Port B pins
	input  wire logic [NUM_PB-1:0] pb_in_i,
	output logic      [NUM_PB-1:0] pb_out_o,
	output logic      [NUM_PB-1:0] pb_oe_o,
	// Timer
	input  wire logic [1:0]        timer_ch_out_i,
	input  wire logic [1:0]        timer_ch_oe_i,
	output logic      [1:0]        timer_ch_in_o,
	output logic                   timer_clk_in_o,
	// Interrupt, reset, keypad, analog
	output logic                   irq_in_n_o,
	output logic                   reset_in_n_o,
	output logic      [5:0]        keypad_in_o,
	output logic      [3:0]        analog_sel_o,
	// Oscillator
	input  wire logic              osc_clk_i,
	input  wire logic              xtal_amp_out_i,
	output logic                   osc_in_o
);

	// Register state
	logic [5:0]        pa_data_q, pa_data_d;
	logic [5:0]        pa_dir_q, pa_dir_d;
	logic [5:0]        pa_pull_q, pa_pull_d;
	logic              clk_out_en_q, clk_out_en_d;
	logic [7:0]        pb_data_q, pb_data_d;
	logic [7:0]        pb_dir_q, pb_dir_d;
	logic [3:0]        an_en_q, an_en_d;
	logic [1:0]        tmr_en_q, tmr_en_d;
	logic              timer_external_clock_in_en_q, timer_external_clock_in_en_d;
	logic              irq_en_q, irq_en_d;
	logic [5:0]        key_en_q, key_en_d;
	logic              rst_en_q, rst_en_d;
	logic              irq_pull_q, irq_pull_d;
	spfm_osc_mode_type osc_mode_q, osc_mode_d;
	logic [7:0]        rdata_d;

	// Arbitration
	logic [NUM_REQ-1:0] req [NUM_PA];
	spfm_drive_type     cand [NUM_PA][4];
	spfm_owner_type     own [NUM_PA];
	logic               oscillator_input_pin_act;
	logic               oscillator_output_pin_act;
	logic [5:0]         pa_read;

	// Registered outputs, next values
	logic [5:0] pa_out_d, pa_oe_d, pa_pullup_d, keypad_in_d;
	logic [7:0] pb_out_d, pb_oe_d;
	logic [3:0] analog_sel_d;
	logic [1:0] timer_ch_in_d;
	logic       pa_schmitt_d, timer_clk_in_d, irq_in_n_d;
	logic       reset_in_n_d, osc_in_d;

	assign pa_read = (pa_dir_q & pa_data_q) | (~pa_dir_q & pa_in_i);

	always_comb begin
		pa_data_d    = pa_data_q;
		pa_dir_d     = pa_dir_q;
		pa_pull_d    = pa_pull_q;
		clk_out_en_d = clk_out_en_q;
		pb_data_d    = pb_data_q;
		pb_dir_d     = pb_dir_q;
		an_en_d      = an_en_q;
		tmr_en_d     = tmr_en_q;
		timer_external_clock_in_en_d    = timer_external_clock_in_en_q;
		irq_en_d     = irq_en_q;
		key_en_d     = key_en_q;
		rst_en_d     = rst_en_q;
		irq_pull_d   = irq_pull_q;
		osc_mode_d   = osc_mode_q;
		rdata_d      = RST_BYTE;
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				OFS_PA_DATA: pa_data_d = reg_wdata_i[5:0];
				OFS_PA_DIR: begin
					pa_dir_d = reg_wdata_i[5:0];
					// R8 no direction bit
					pa_dir_d[IN_ONLY_PIN] = 1'b0;
				end
				OFS_PA_PULL: begin
					pa_pull_d    = reg_wdata_i[5:0];
					clk_out_en_d = reg_wdata_i[PU_CLKOUT_BIT];
				end
				OFS_PB_DATA: pb_data_d = reg_wdata_i;
				OFS_PB_DIR: pb_dir_d = reg_wdata_i;
				OFS_FUNC_EN: begin
					an_en_d   = reg_wdata_i[FE_ANALOG_LSB +: 4];
					tmr_en_d  = reg_wdata_i[FE_TIMER_LSB +: 2];
					timer_external_clock_in_en_d = reg_wdata_i[FE_TIMER_EXTERNAL_CLOCK_IN_BIT];
					irq_en_d  = reg_wdata_i[FE_IRQ_BIT];
				end
				OFS_KEY_EN: begin
					key_en_d   = reg_wdata_i[KE_KEYPAD_LSB +: 6];
					rst_en_d   = reg_wdata_i[KE_RESET_BIT];
					irq_pull_d = reg_wdata_i[KE_IRQ_PULL_BIT];
				end
				OFS_OSC_CFG: begin
					osc_mode_d = spfm_osc_mode_type'(
						reg_wdata_i[OC_MODE_LSB +: 2]);
				end
				default: begin
				end
			endcase
		end
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				OFS_PA_DATA: rdata_d = {2'b00, pa_read};
				OFS_PA_DIR: rdata_d = {2'b00, pa_dir_q};
				OFS_PA_PULL: rdata_d = {clk_out_en_q, 1'b0, pa_pull_q};
				// R11 absent port reads zero
				OFS_PB_DATA: rdata_d = HAS_PORT_B ?
					((pb_dir_q & pb_data_q) | (~pb_dir_q & pb_in_i)) : RST_PB;
				OFS_PB_DIR: rdata_d = HAS_PORT_B ? pb_dir_q : RST_PB;
				OFS_FUNC_EN: rdata_d = {irq_en_q, timer_external_clock_in_en_q, tmr_en_q, an_en_q};
				OFS_KEY_EN: rdata_d = {irq_pull_q, rst_en_q, key_en_q};
				OFS_OSC_CFG: rdata_d = {6'h00, osc_mode_q};
				OFS_OWNER_LO: rdata_d = {own[3], own[2], own[1], own[0]};
				OFS_OWNER_HI: rdata_d = {4'h0, own[5], own[4]};
				default: rdata_d = RST_BYTE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		// R1 reset to inputs
		if (rst_i) begin
			pa_data_q    <= RST_PA;
			pa_dir_q     <= RST_PA;
			pa_pull_q    <= RST_PA;
			clk_out_en_q <= 1'b0;
			pb_data_q    <= RST_PB;
			pb_dir_q     <= RST_PB;
			an_en_q      <= 4'h0;
			tmr_en_q     <= 2'h0;
			timer_external_clock_in_en_q    <= 1'b0;
			irq_en_q     <= 1'b0;
			key_en_q     <= 6'h00;
			rst_en_q     <= 1'b0;
			irq_pull_q   <= 1'b0;
			osc_mode_q   <= OSC_INTERNAL;
			reg_rdata_o  <= RST_BYTE;
		end else begin
			pa_data_q    <= pa_data_d;
			pa_dir_q     <= pa_dir_d;
			pa_pull_q    <= pa_pull_d;
			clk_out_en_q <= clk_out_en_d;
			pb_data_q    <= pb_data_d;
			pb_dir_q     <= pb_dir_d;
			an_en_q      <= an_en_d;
			tmr_en_q     <= tmr_en_d;
			timer_external_clock_in_en_q    <= timer_external_clock_in_en_d;
			irq_en_q     <= irq_en_d;
			key_en_q     <= key_en_d;
			rst_en_q     <= rst_en_d;
			irq_pull_q   <= irq_pull_d;
			osc_mode_q   <= osc_mode_d;
			reg_rdata_o  <= rdata_d;
		end
	end

	// External clock mode leaves pin 4 free for other use
	assign oscillator_input_pin_act = (osc_mode_q != OSC_INTERNAL);
	// R9 clock out gated
	// R10 crystal overrides
	assign oscillator_output_pin_act = (osc_mode_q == OSC_CRYSTAL) ||
		(((osc_mode_q == OSC_INTERNAL) || (osc_mode_q == OSC_RC)) &&
		clk_out_en_q);

	always_comb begin
		for (int p = 0; p < NUM_PA; p++) begin
			for (int c = 0; c < 3; c++) begin
				cand[p][c] = '{dout: 1'b0, oe: 1'b0};
			end
			cand[p][3] = '{dout: pa_data_q[p], oe: pa_dir_q[p]};
		end
		// R2 pin 0 order
		req[0] = {key_en_q[0], tmr_en_q[0], an_en_q[0]};
		cand[0][1] = '{dout: timer_ch_out_i[0], oe: timer_ch_oe_i[0]};
		// R3 pin 1 order
		req[1] = {key_en_q[1], tmr_en_q[1], an_en_q[1]};
		cand[1][1] = '{dout: timer_ch_out_i[1], oe: timer_ch_oe_i[1]};
		// R4 pin 2 order
		req[2] = {timer_external_clock_in_en_q, key_en_q[2], irq_en_q};
		// R5 pin 3 order
		req[3] = {1'b0, key_en_q[3], rst_en_q};
		// R6 pin 4 order
		req[4] = {key_en_q[4], an_en_q[2], oscillator_output_pin_act};
		cand[4][0] = '{dout: (osc_mode_q == OSC_CRYSTAL) ?
			xtal_amp_out_i : osc_clk_i, oe: 1'b1};
		// R7 pin 5 order
		req[5] = {key_en_q[5], an_en_q[3], oscillator_input_pin_act};
	end

	genvar gp;
	generate
		for (gp = 0; gp < NUM_PA; gp++) begin : g_pin
			spfm_prio_sel #(
				.N (NUM_REQ)
			) u_sel (
				.req_i   (req[gp]),
				.owner_o (own[gp])
			);
		end
	endgenerate

	always_comb begin
		for (int p = 0; p < NUM_PA; p++) begin
			// R13 winner drives pin
			pa_out_d[p]    = cand[p][own[p]].dout;
			pa_oe_d[p]     = cand[p][own[p]].oe;
			pa_pullup_d[p] = pa_pull_q[p];
		end
		// R8 never driven
		pa_out_d[IN_ONLY_PIN] = 1'b0;
		pa_oe_d[IN_ONLY_PIN]  = 1'b0;
		// R12 interrupt conditioning, plus forced pin 3 pullup for the reset input
		pa_schmitt_d = (own[2] == OWN_FIRST);
		if (own[2] == OWN_FIRST) begin
			pa_pullup_d[2] = irq_pull_q;
		end
		if (own[3] == OWN_FIRST) begin
			pa_pullup_d[3] = 1'b1;
		end
		// R13 capture by owner
		analog_sel_d[0] = (own[0] == OWN_FIRST);
		analog_sel_d[1] = (own[1] == OWN_FIRST);
		analog_sel_d[2] = (own[4] == OWN_SECOND);
		analog_sel_d[3] = (own[5] == OWN_SECOND);
		timer_ch_in_d[0] = (own[0] == OWN_SECOND) & pa_in_i[0];
		timer_ch_in_d[1] = (own[1] == OWN_SECOND) & pa_in_i[1];
		timer_clk_in_d = (own[2] == OWN_THIRD) & pa_in_i[2];
		irq_in_n_d = (own[2] == OWN_FIRST) ? pa_in_i[2] : 1'b1;
		reset_in_n_d = (own[3] == OWN_FIRST) ? pa_in_i[3] : 1'b1;
		osc_in_d = (own[5] == OWN_FIRST) & pa_in_i[5];
		// Idle keypad lines sit high, as if pulled up
		keypad_in_d[0] = (own[0] == OWN_THIRD) ? pa_in_i[0] : 1'b1;
		keypad_in_d[1] = (own[1] == OWN_THIRD) ? pa_in_i[1] : 1'b1;
		keypad_in_d[2] = (own[2] == OWN_SECOND) ? pa_in_i[2] : 1'b1;
		keypad_in_d[3] = (own[3] == OWN_SECOND) ? pa_in_i[3] : 1'b1;
		keypad_in_d[4] = (own[4] == OWN_THIRD) ? pa_in_i[4] : 1'b1;
		keypad_in_d[5] = (own[5] == OWN_THIRD) ? pa_in_i[5] : 1'b1;
		// R11 port B optional
		pb_out_d = HAS_PORT_B ? pb_data_q : RST_PB;
		pb_oe_d  = HAS_PORT_B ? pb_dir_q : RST_PB;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pa_out_o       <= RST_PA;
			pa_oe_o        <= RST_PA;
			pa_pullup_o    <= RST_PA;
			pa_schmitt_o   <= 1'b0;
			pb_out_o       <= RST_PB;
			pb_oe_o        <= RST_PB;
			timer_ch_in_o  <= 2'h0;
			timer_clk_in_o <= 1'b0;
			irq_in_n_o     <= 1'b1;
			reset_in_n_o   <= 1'b1;
			keypad_in_o    <= 6'h3F;
			analog_sel_o   <= 4'h0;
			osc_in_o       <= 1'b0;
		end else begin
			pa_out_o       <= pa_out_d;
			pa_oe_o        <= pa_oe_d;
			pa_pullup_o    <= pa_pullup_d;
			pa_schmitt_o   <= pa_schmitt_d;
			pb_out_o       <= pb_out_d;
			pb_oe_o        <= pb_oe_d;
			timer_ch_in_o  <= timer_ch_in_d;
			timer_clk_in_o <= timer_clk_in_d;
			irq_in_n_o     <= irq_in_n_d;
			reset_in_n_o   <= reset_in_n_d;
			keypad_in_o    <= keypad_in_d;
			analog_sel_o   <= analog_sel_d;
			osc_in_o       <= osc_in_d;
		end
	end

	property p_reset_inputs;
		@(posedge clk_i) disable iff (rst_i)
		$past(rst_i) |-> (pa_oe_o == 6'h00) && (analog_sel_o == 4'h0);
	endproperty
	a_reset_inputs: assert property (p_reset_inputs) // R1
		else $error("pins not inputs after reset");

	property p_pin0_analog;
		@(posedge clk_i) disable iff (rst_i)
		an_en_q[0] |=> analog_sel_o[0] && !pa_oe_o[0] && !timer_ch_in_o[0];
	endproperty
	a_pin0_analog: assert property (p_pin0_analog) // R2
		else $error("analog 0 lost pin 0");

	property p_pin1_timer;
		@(posedge clk_i) disable iff (rst_i)
		!an_en_q[1] && tmr_en_q[1] |=>
			(pa_out_o[1] == $past(timer_ch_out_i[1])) &&
			(pa_oe_o[1] == $past(timer_ch_oe_i[1]));
	endproperty
	a_pin1_timer: assert property (p_pin1_timer) // R3
		else $error("timer 1 not driving pin 1");

	property p_pin2_irq;
		@(posedge clk_i) disable iff (rst_i)
		irq_en_q |=> (irq_in_n_o == $past(pa_in_i[2])) && keypad_in_o[2] &&
			!timer_clk_in_o;
	endproperty
	a_pin2_irq: assert property (p_pin2_irq) // R4
		else $error("interrupt not owning pin 2");

	property p_pin3_reset;
		@(posedge clk_i) disable iff (rst_i)
		rst_en_q |=> (reset_in_n_o == $past(pa_in_i[3])) && !pa_oe_o[3];
	endproperty
	a_pin3_reset: assert property (p_pin3_reset) // R5
		else $error("reset input not owning pin 3");

	property p_pin5_osc;
		@(posedge clk_i) disable iff (rst_i)
		oscillator_input_pin_act |=> (osc_in_o == $past(pa_in_i[5])) && !analog_sel_o[3];
	endproperty
	a_pin5_osc: assert property (p_pin5_osc) // R7
		else $error("oscillator input not owning pin 5");

	property p_pin2_no_drive;
		@(posedge clk_i) disable iff (rst_i)
		##1 !pa_oe_o[2] && !pa_out_o[2];
	endproperty
	a_pin2_no_drive: assert property (p_pin2_no_drive) // R8
		else $error("input-only pin driven");

	property p_clock_out;
		@(posedge clk_i) disable iff (rst_i)
		(osc_mode_q == OSC_INTERNAL) && clk_out_en_q |=>
			pa_oe_o[4] && (pa_out_o[4] == $past(osc_clk_i));
	endproperty
	a_clock_out: assert property (p_clock_out) // R9
		else $error("clock out missing on pin 4");

	property p_no_clock_out;
		@(posedge clk_i) disable iff (rst_i)
		(osc_mode_q == OSC_RC) && !clk_out_en_q && (an_en_q[2] == 1'b0) &&
			!key_en_q[4] |=> (pa_oe_o[4] == $past(pa_dir_q[4]));
	endproperty
	a_no_clock_out: assert property (p_no_clock_out) // R6
		else $error("pin 4 not returned to port");

	property p_crystal;
		@(posedge clk_i) disable iff (rst_i)
		osc_mode_q == OSC_CRYSTAL |=>
			pa_oe_o[4] && (pa_out_o[4] == $past(xtal_amp_out_i));
	endproperty
	a_crystal: assert property (p_crystal) // R10
		else $error("crystal amplifier not on pin 4");

	property p_port_b;
		@(posedge clk_i) disable iff (rst_i)
		##1 (pb_oe_o == (HAS_PORT_B ? $past(pb_dir_q) : RST_PB)) &&
			(pb_out_o == (HAS_PORT_B ? $past(pb_data_q) : RST_PB));
	endproperty
	a_port_b: assert property (p_port_b) // R11
		else $error("absent port B driven");

	property p_irq_cond;
		@(posedge clk_i) disable iff (rst_i)
		irq_en_q |=> pa_schmitt_o && (pa_pullup_o[2] == $past(irq_pull_q));
	endproperty
	a_irq_cond: assert property (p_irq_cond) // R12
		else $error("interrupt conditioning wrong");

	property p_keypad_low;
		@(posedge clk_i) disable iff (rst_i)
		key_en_q[0] && !an_en_q[0] && !tmr_en_q[0] |=>
			(keypad_in_o[0] == $past(pa_in_i[0])) && !pa_oe_o[0];
	endproperty
	a_keypad_low: assert property (p_keypad_low) // R13
		else $error("keypad 0 not owning pin 0");

endmodule
`default_nettype wire

// ---- pkg/spfm_pkg.sv ----
// Purpose: Shared constants and types for the shared pin function mux.
// Assumes: 8-bit register port, 4-bit register address.
// Notes:   Offsets, field positions and port reset values live here only.
`default_nettype none
package spfm_pkg;

	// Widths
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned NUM_PA = 6;
	localparam int unsigned NUM_PB = 8;
	localparam int unsigned NUM_REQ = 3;

	// Register offsets
	localparam logic [3:0] OFS_PA_DATA  = 4'h0;
	localparam logic [3:0] OFS_PA_DIR   = 4'h1;
	localparam logic [3:0] OFS_PA_PULL  = 4'h2;
	localparam logic [3:0] OFS_PB_DATA  = 4'h3;
	localparam logic [3:0] OFS_PB_DIR   = 4'h4;
	localparam logic [3:0] OFS_FUNC_EN  = 4'h5;
	localparam logic [3:0] OFS_KEY_EN   = 4'h6;
	localparam logic [3:0] OFS_OSC_CFG  = 4'h7;
	localparam logic [3:0] OFS_OWNER_LO = 4'h8;
	localparam logic [3:0] OFS_OWNER_HI = 4'h9;

	// Field positions
	localparam int unsigned FE_ANALOG_LSB   = 0;
	localparam int unsigned FE_TIMER_LSB    = 4;
	localparam int unsigned FE_TIMER_EXTERNAL_CLOCK_IN_BIT     = 6;
	localparam int unsigned FE_IRQ_BIT      = 7;
	localparam int unsigned KE_KEYPAD_LSB   = 0;
	localparam int unsigned KE_RESET_BIT    = 6;
	localparam int unsigned KE_IRQ_PULL_BIT = 7;
	localparam int unsigned PU_CLKOUT_BIT   = 7;
	localparam int unsigned OC_MODE_LSB     = 0;
	localparam int unsigned IN_ONLY_PIN     = 2;

	// Values after reset
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [5:0] RST_PA   = 6'h00;
	localparam logic [7:0] RST_PB   = 8'h00;

	typedef enum logic [1:0] {
		OSC_INTERNAL = 2'b00,
		OSC_EXTERNAL = 2'b01,
		OSC_RC       = 2'b10,
		OSC_CRYSTAL  = 2'b11
	} spfm_osc_mode_type;

	typedef enum logic [1:0] {
		OWN_FIRST  = 2'b00,
		OWN_SECOND = 2'b01,
		OWN_THIRD  = 2'b10,
		OWN_GPIO   = 2'b11
	} spfm_owner_type;

	typedef struct packed {
		logic dout;
		logic oe;
	} spfm_drive_type;

endpackage
`default_nettype wire

// ---- verilog/spfm_prio_sel.sv ----
// Purpose: Fixed priority picker for one shared pin.
// Assumes: Request 0 is the highest priority function.
// Notes:   No request at all leaves the pin to the port logic.
`default_nettype none
module spfm_prio_sel
	import spfm_pkg::*;
#(
	parameter int unsigned N = NUM_REQ
) (
	// Requests
	input  wire logic [N-1:0]   req_i,
	// Winner
	output var  spfm_owner_type owner_o
);

	always_comb begin
		owner_o = OWN_GPIO;
		// R13 highest wins
		for (int i = N - 1; i >= 0; i--) begin
			if (req_i[i]) begin
				owner_o = spfm_owner_type'(2'(i));
			end
		end
	end

endmodule
`default_nettype wire

// ---- bench/test_spfm_mux.sv ----
// Purpose: Self-checking bench for the shared pin function mux.
// Assumes: Register map and one-cycle pin latency of spfm_mux.
// Notes:   LFSR configurations plus fixed corner cases; a model predicts.
`default_nettype none
module test_spfm_mux
	import spfm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic              clk     = 1'b0;
	logic              rst     = 1'b1;
	logic [ADDR_W-1:0] addr    = 4'h0;
	logic [DATA_W-1:0] wdata   = 8'h00;
	logic              wr      = 1'b0;
	logic              rd      = 1'b0;
	logic [NUM_PA-1:0] pa_in   = 6'h00;
	logic [NUM_PB-1:0] pb_in   = 8'h00;
	logic [1:0]        t_out   = 2'h0;
	logic [1:0]        t_oe    = 2'h0;
	logic              osc_clk = 1'b0;
	logic              xtal    = 1'b0;
	logic [DATA_W-1:0] rdata;
	logic [DATA_W-1:0] rdata_s;
	logic [NUM_PA-1:0] pa_out, pa_oe, pa_pu;
	logic [NUM_PB-1:0] pb_out, pb_oe;
	logic [NUM_PB-1:0] pb_out_s, pb_oe_s;
	logic              schmitt, timer_external_clock_in, irq_n, rst_n, osc_in;
	logic [1:0]        t_in;
	logic [5:0]        kp_in;
	logic [3:0]        an_sel;
	logic [31:0]       seed    = 32'hC7662B49;
	logic [7:0]        fe, ke, pu, dir, dat, got;
	logic [1:0]        oc;
	logic [1:0]        own [6];
	int                miscompares = 0;
	int                check_count = 0;

	spfm_mux dut (
		.clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
		.pa_in_i(pa_in), .pa_out_o(pa_out), .pa_oe_o(pa_oe),
		.pa_pullup_o(pa_pu), .pa_schmitt_o(schmitt), .pb_in_i(pb_in),
		.pb_out_o(pb_out), .pb_oe_o(pb_oe), .timer_ch_out_i(t_out),
		.timer_ch_oe_i(t_oe), .timer_ch_in_o(t_in), .timer_clk_in_o(timer_external_clock_in),
		.irq_in_n_o(irq_n), .reset_in_n_o(rst_n), .keypad_in_o(kp_in),
		.analog_sel_o(an_sel), .osc_clk_i(osc_clk), .xtal_amp_out_i(xtal),
		.osc_in_o(osc_in)
	);

	// Small package variant, no port B
	spfm_mux #(.HAS_PORT_B(1'b0)) dut_small (
		.clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata_s),
		.pa_in_i(pa_in), .pa_out_o(), .pa_oe_o(), .pa_pullup_o(),
		.pa_schmitt_o(), .pb_in_i(pb_in), .pb_out_o(pb_out_s),
		.pb_oe_o(pb_oe_s), .timer_ch_out_i(t_out), .timer_ch_oe_i(t_oe),
		.timer_ch_in_o(), .timer_clk_in_o(), .irq_in_n_o(),
		.reset_in_n_o(), .keypad_in_o(), .analog_sel_o(),
		.osc_clk_i(osc_clk), .xtal_amp_out_i(xtal), .osc_in_o()
	);

	initial begin
		forever #2 clk = ~clk;
	end

	function automatic logic [1:0] pick(input logic a, b, c);
		return a ? 2'h0 : (b ? 2'h1 : (c ? 2'h2 : 2'h3));
	endfunction

	function automatic logic [7:0] draw();
		seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h00000000);
		return seed[15:8];
	endfunction

	task automatic chk(input string name, input logic [7:0] exp,
		input logic [7:0] act);
		check_count++;
		if (act !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", name, exp, act);
		end
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	// Owner codes as the priority chains dictate
	function automatic void predict();
		own[0] = pick(fe[0], fe[4], ke[0]);
		own[1] = pick(fe[1], fe[5], ke[1]);
		own[2] = pick(fe[7], ke[2], fe[6]);
		own[3] = pick(ke[6], ke[3], 1'b0);
		own[4] = pick(oc == 2'h3 || (oc != 2'h1 && pu[7]), fe[2], ke[4]);
		own[5] = pick(oc != 2'h0, fe[3], ke[5]);
	endfunction

	task automatic check_pins();
		logic [5:0] oe;
		logic [5:0] out;
		logic [5:0] kp;
		for (int n = 0; n < 6; n++) begin
			oe[n] = (own[n] == 2'h3) ? dir[n] : 1'b0;
			out[n] = (own[n] == 2'h3) ? dat[n] : 1'b0;
			kp[n] = (own[n] == ((n == 2 || n == 3) ? 2'h1 : 2'h2)) ?
				pa_in[n] : 1'b1;
		end
		oe[2] = 1'b0;
		out[2] = 1'b0;
		for (int n = 0; n < 2; n++) begin
			if (own[n] == 2'h1) begin
				oe[n] = t_oe[n];
				out[n] = t_out[n];
			end
		end
		if (own[4] == 2'h0) begin
			oe[4] = 1'b1;
			out[4] = (oc == 2'h3) ? xtal : osc_clk;
		end
		chk("pa_oe", {2'h0, oe}, {2'h0, pa_oe});
		chk("pa_out", {2'h0, out}, {2'h0, pa_out});
		chk("keypad_in", {2'h0, kp}, {2'h0, kp_in});
		chk("analog_sel", {4'h0, own[5] == 2'h1, own[4] == 2'h1,
			own[1] == 2'h0, own[0] == 2'h0}, {4'h0, an_sel});
		chk("fn_inputs", {1'b0, own[2] == 2'h0,
			(own[2] == 2'h0) ? pa_in[2] : 1'b1,
			(own[3] == 2'h0) ? pa_in[3] : 1'b1,
			(own[2] == 2'h2) ? pa_in[2] : 1'b0,
			(own[5] == 2'h0) ? pa_in[5] : 1'b0,
			(own[1] == 2'h1) ? pa_in[1] : 1'b0,
			(own[0] == 2'h1) ? pa_in[0] : 1'b0},
			{1'b0, schmitt, irq_n, rst_n, timer_external_clock_in, osc_in, t_in});
		chk("pullup", {2'h0, pu[5:4], (own[3] == 2'h0) ? 1'b1 : pu[3],
			(own[2] == 2'h0) ? ke[7] : pu[2], pu[1:0]},
			{2'h0, pa_pu});
		rd_reg(OFS_OWNER_LO, got);
		chk("owner_lo", {own[3], own[2], own[1], own[0]}, got);
		rd_reg(OFS_OWNER_HI, got);
		chk("owner_hi", {4'h0, own[5], own[4]}, got);
		rd_reg(OFS_PA_DATA, got);
		chk("pa_data", {2'h0, (dir[5:0] & 6'h3B & dat[5:0]) |
			(~(dir[5:0] & 6'h3B) & pa_in)}, got);
	endtask

	task automatic run(input logic [7:0] f, k, p, d, t,
		input logic [1:0] o);
		fe = f;
		ke = k;
		pu = p;
		dir = d;
		dat = t;
		oc = o;
		wr_reg(OFS_FUNC_EN, fe);
		wr_reg(OFS_KEY_EN, ke);
		wr_reg(OFS_PA_PULL, pu);
		wr_reg(OFS_OSC_CFG, {6'h00, oc});
		wr_reg(OFS_PA_DIR, dir);
		wr_reg(OFS_PA_DATA, dat);
		predict();
		repeat (2) @(posedge clk);
		#1;
		check_pins();
	endtask

	task automatic do_reset();
		@(posedge clk);
		rst <= 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		{fe, ke, pu, dir, dat} = 40'h0;
		oc = 2'h0;
		predict();
		repeat (2) @(posedge clk);
		#1;
		check_pins();
	endtask

	task automatic end_sim();
		$display("checks %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		end_sim();
	end

	initial begin
		logic [7:0] r [7];
		pa_in <= 6'h2D;
		t_out <= 2'h2;
		t_oe <= 2'h3;
		osc_clk <= 1'b1;
		do_reset();
		$display("test reset done");
		// Everything enabled, then peeled back layer by layer
		run(8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h2A, 2'h3);
		run(8'h70, 8'h3F, 8'h00, 8'h3F, 8'h15, 2'h0);
		run(8'h40, 8'h3F, 8'h80, 8'h3F, 8'h3F, 2'h1);
		run(8'h0C, 8'h00, 8'h80, 8'h3F, 8'h00, 2'h2);
		run(8'h4C, 8'h00, 8'h00, 8'h3F, 8'h3F, 2'h0);
		run(8'h00, 8'h00, 8'h00, 8'h3F, 8'h15, 2'h0);
		run(8'h00, 8'h00, 8'h00, 8'h3F, 8'h15, 2'h2);
		$display("test corners done");
		for (int i = 0; i < 40; i++) begin
			for (int j = 0; j < 7; j++) begin
				r[j] = draw();
			end
			@(posedge clk);
			pa_in <= r[6][5:0];
			t_out <= r[6][7:6];
			t_oe <= r[5][7:6];
			osc_clk <= r[4][6];
			xtal <= r[3][6];
			run(r[0], r[1], r[2], r[3], r[4], r[5][1:0]);
		end
		$display("test random done");
		do_reset();
		$display("test second reset done");
		@(posedge clk);
		pb_in <= 8'hA5;
		wr_reg(OFS_PB_DIR, 8'hF0);
		wr_reg(OFS_PB_DATA, 8'h3C);
		repeat (2) @(posedge clk);
		#1;
		chk("pb_oe", 8'hF0, pb_oe);
		chk("pb_out", 8'h3C, pb_out);
		chk("pb_oe_small", 8'h00, pb_oe_s);
		chk("pb_out_small", 8'h00, pb_out_s);
		rd_reg(OFS_PB_DATA, got);
		chk("pb_data", 8'h35, got);
		chk("pb_data_small", 8'h00, rdata_s);
		$display("test port b done");
		wr_reg(4'hA, 8'hFF);
		for (int a = 10; a < 16; a++) begin
			rd_reg(4'(a), got);
			chk("unmapped", 8'h00, got);
		end
		rd_reg(OFS_FUNC_EN, got);
		chk("func_en", 8'h00, got);
		@(posedge clk);
		#1;
		chk("rdata_idle", 8'h00, rdata);
		$display("test register port done");
		end_sim();
	end
endmodule
`default_nettype wire
